/* File: inc/swwc_pkg.sv */
// Package: constants and carriers for sleep and watchdog control
package swwc_pkg;
   // ==========================================================
   // Register indexes on the plain port
   localparam logic [3:0] ADDR_INTERRUPT_CONTROL_MAIN   = 4'h0;
   localparam logic [3:0] ADDR_PIN_CHANGE_ENABLE_A     = 4'h1;
   localparam logic [3:0] ADDR_PIN_CHANGE_ENABLE_B     = 4'h2;
   localparam logic [3:0] ADDR_PERIPHERAL_IRQ_ENABLE_A     = 4'h3;
   localparam logic [3:0] ADDR_PERIPHERAL_IRQ_ENABLE_B     = 4'h4;
   localparam logic [3:0] ADDR_PERIPHERAL_IRQ_FLAGS_A     = 4'h5;
   localparam logic [3:0] ADDR_PERIPHERAL_IRQ_FLAGS_B     = 4'h6;
   localparam logic [3:0] ADDR_STATUS   = 4'h7;
   localparam logic [3:0] ADDR_OPTION   = 4'h8;
   localparam logic [3:0] ADDR_FUSE_LO  = 4'h9;
   localparam logic [3:0] ADDR_FUSE_HI  = 4'hA;
   localparam logic [3:0] ADDR_SLPSTAT  = 4'hB;
   // ==========================================================
   // Field positions
   localparam int GIE_BIT   = 7;
   localparam int INTE_BIT  = 4;
   localparam int IOCE_BIT  = 3;
   localparam int INTF_BIT  = 1;
   localparam int IOCF_BIT  = 0;
   localparam int TO_BIT    = 4;
   localparam int PD_BIT    = 3;
   localparam int PSA_BIT   = 3;
   localparam int WATCHDOG_ENABLE_FUSE_BIT  = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  INTERRUPT_CONTROL_MAIN_RST = 8'h00;
   localparam logic [7:0]  OPTION_RST = 8'hFF;
   localparam logic [7:0]  STATUS_RST = 8'h18;
   localparam logic [7:0]  ZERO8      = 8'h00;
   localparam logic [13:0] FUSE_DEF   = 14'h3FFF;
   // ==========================================================
   // Timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int WDT_PERIOD_MS = 18;
   localparam int WDT_CYCLES    = CLK_HZ / 1000 * WDT_PERIOD_MS;
   localparam int PRESC_W       = 7;
   // ==========================================================
   typedef enum logic [1:0] {
      SWWC_RUN   = 2'b00,
      SWWC_SLEEP = 2'b01,
      SWWC_WAKE  = 2'b10
   } swwc_state_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } swwc_bus_s;

   typedef struct packed {
      logic sleep_op;
      logic watchdog_clear_op_op;
   } swwc_op_s;
endpackage : swwc_pkg

/* File: src/swwc_wdog.sv */
// Watchdog counter with shared prescaler stage
`timescale 1ns/1ps
module swwc_wdog #(
   parameter int WDT_TICKS = swwc_pkg::WDT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       clear,
   input  wire logic       presc_on,
   input  wire logic [2:0] ratio,
   output logic            timeout
);
   // ==========================================================
   // Base period counter
   logic [31:0]                  base_q;
   logic [swwc_pkg::PRESC_W-1:0] presc_q;
   logic                         base_tick;
   logic                         presc_done;

   assign base_tick  = enable && (base_q == 32'(WDT_TICKS - 1));
   // Ratio n gives 1:2^n, so 7 gives 1:128
   assign presc_done = !presc_on ||
      (presc_q == 7'((8'h01 << ratio) - 8'h01));

   always_ff @(posedge clk) begin
      if (rst || clear || !enable || base_tick)
         base_q <= 32'h0;
      else
         base_q <= base_q + 32'h1;
   end

   always_ff @(posedge clk) begin
      if (rst || clear || !enable)
         presc_q <= 7'h00;
      else if (base_tick)
         presc_q <= presc_done ? 7'h00 : presc_q + 7'h01;
   end

   always_ff @(posedge clk) begin
      if (rst || clear)
         timeout <= 1'b0;
      else
         timeout <= base_tick && presc_done;
   end
endmodule : swwc_wdog

/* File: src/swwc_core.sv */
// Sleep, wake-up and watchdog control for a small core
// ==========================================================
// Summary of operation
// - Power-down instruction clears watchdog; it keeps counting in sleep.
// - Entering sleep clears power_down_flag and sets timeout_flag.
// - CPU clock enable is low throughout sleep.
// - Pin drive values and enables are frozen during sleep.
// - Only the watchdog reset changes behaviour in sleep; brown-out resets as when awake.
// - Analog supply removed in sleep; analog enable settings kept.
// - Power-on reset while asleep wakes the device.
// - Seven wake sources; reset pin, power-on and brown-out reset the core.
// - Pin-change and edge-pin interrupts can wake the device.
// - Next instruction is prefetched while power-down executes.
// - Interrupt wakes only if its own enable set, ignoring global enable.
// - After wake run next instruction, then vector only if global enable.
// - Watchdog cleared on every interrupt or timeout wake-up; reset wakes do not clear it.
// - Pending enabled interrupt makes power-down a no-operation.
// - Interrupt during power-down: complete, wake at once, clear watchdog.
// - Watchdog runs only while its fuse is set; fuse default is set.
// - Timeout resets when running, wakes when asleep.
// - Nominal 18 ms timeout, prescaler up to 1:128.
// - Software may reassign the prescaler at any time.
// - Clear op and power-down clear counter and assigned prescaler.
// - Watchdog timeout clears timeout_flag.
// - Fuse low byte bit 3 is watchdog enable; unused bits read one.
`timescale 1ns/1ps
module swwc_core #(
   parameter int WDT_TICKS = swwc_pkg::WDT_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire swwc_pkg::swwc_bus_s bus,
   output logic [7:0]               rdata,
   input  wire swwc_pkg::swwc_op_s  op,
   input  wire logic [13:0]         fuse_word,
   input  wire logic                reset_pin_n,
   input  wire logic                por_event,
   input  wire logic                bor_event,
   input  wire logic                edge_pin,
   input  wire logic [7:0]          pins_a_in,
   input  wire logic [7:0]          pins_b_in,
   input  wire logic [7:0]          periph_flags_a,
   input  wire logic [7:0]          periph_flags_b,
   input  wire logic [7:0]          io_out_core,
   input  wire logic [7:0]          io_oe_core,
   input  wire logic [7:0]          analog_en_core,
   output logic                     cpu_clk_en,
   output logic                     core_reset,
   output logic                     prefetch_next,
   output logic                     vector_irq,
   output logic                     analog_supply_rail,
   output logic [7:0]               analog_en,
   output logic [7:0]               io_out,
   output logic [7:0]               io_oe,
   output logic                     asleep
);
   // ==========================================================
   // Pin synchronisers
   logic [1:0] rpin_s, epin_s, por_s, bor_s;
   logic [7:0] pa_s1, pa_s2, pb_s1, pb_s2;
   logic       epin_d1;

   always_ff @(posedge clk) begin
      rpin_s  <= {rpin_s[0], reset_pin_n};
      epin_s  <= {epin_s[0], edge_pin};
      por_s   <= {por_s[0], por_event};
      bor_s   <= {bor_s[0], bor_event};
      pa_s1   <= pins_a_in;
      pa_s2   <= pa_s1;
      pb_s1   <= pins_b_in;
      pb_s2   <= pb_s1;
      epin_d1 <= epin_s[1];
   end

   // ==========================================================
   // Registers
   logic [7:0]  interrupt_control_main_q, pin_change_enable_a_q, pin_change_enable_b_q, peripheral_irq_enable_a_q, peripheral_irq_enable_b_q;
   logic [7:0]  status_q, option_q;
   logic [13:0] fuse_q;
   logic [7:0]  pa_last_q, pb_last_q;
   swwc_pkg::swwc_state_e state_q;
   logic        wdt_timeout;
   logic        wdt_clear;
   logic        wdt_en;
   logic        pin_change, edge_hit, periph_any, irq_pending;
   logic        do_sleep, wake_irq, reset_req;

   function automatic logic wr_hit(input logic [3:0] a);
      wr_hit = bus.wr && (bus.addr == a);
   endfunction : wr_hit

   // Edge on rising level of the edge pin
   assign edge_hit   = epin_s[1] && !epin_d1;
   assign pin_change = |((pa_s2 ^ pa_last_q) & pin_change_enable_a_q) ||
                       |((pb_s2 ^ pb_last_q) & pin_change_enable_b_q);
   assign periph_any = |(periph_flags_a & peripheral_irq_enable_a_q) ||
                       |(periph_flags_b & peripheral_irq_enable_b_q);
   // Individual enables only; global enable ignored for waking
   assign irq_pending =
      (interrupt_control_main_q[swwc_pkg::INTE_BIT] && interrupt_control_main_q[swwc_pkg::INTF_BIT]) ||
      (interrupt_control_main_q[swwc_pkg::IOCE_BIT] && interrupt_control_main_q[swwc_pkg::IOCF_BIT]) ||
      periph_any;
   // Fuse set means running, no software way to stop it
   assign wdt_en    = fuse_q[swwc_pkg::WATCHDOG_ENABLE_FUSE_BIT];
   assign do_sleep  = op.sleep_op && state_q == swwc_pkg::SWWC_RUN &&
                      !irq_pending;
   assign wake_irq  = state_q == swwc_pkg::SWWC_SLEEP &&
                      (irq_pending || wdt_timeout);
   // Reset pin, power-on and brown-out act the same asleep or awake
   assign reset_req = !rpin_s[1] || por_s[1] || bor_s[1] ||
                      (wdt_timeout &&
                       state_q != swwc_pkg::SWWC_SLEEP);
   assign wdt_clear = op.watchdog_clear_op_op || do_sleep ||
                      state_q == swwc_pkg::SWWC_WAKE;

   // Fuse is captured after reset release and again on every core reset
   always_ff @(posedge clk) begin
      if (rst)
         fuse_q <= swwc_pkg::FUSE_DEF;
      else if (core_reset)
         // Implemented bits: 13, 11, 10, 8 and 6 down to 3
         fuse_q <= fuse_word | ~14'h2D78;
   end

   // ==========================================================
   // Watchdog
   swwc_wdog #(.WDT_TICKS(WDT_TICKS)) u_wdog (
      .clk      (clk),
      .rst      (rst),
      .enable   (wdt_en),
      .clear    (wdt_clear),
      .presc_on (option_q[swwc_pkg::PSA_BIT]),
      .ratio    (option_q[2:0]),
      .timeout  (wdt_timeout)
   );

   // ==========================================================
   // Sleep state machine
   always_ff @(posedge clk) begin
      if (rst || reset_req)
         state_q <= swwc_pkg::SWWC_RUN;
      else begin
         case (state_q)
            swwc_pkg::SWWC_RUN:
               if (do_sleep)
                  state_q <= swwc_pkg::SWWC_SLEEP;
            swwc_pkg::SWWC_SLEEP:
               if (wake_irq)
                  state_q <= swwc_pkg::SWWC_WAKE;
            swwc_pkg::SWWC_WAKE:
               state_q <= swwc_pkg::SWWC_RUN;
            default:
               state_q <= swwc_pkg::SWWC_RUN;
         endcase
      end
   end

   // ==========================================================
   // Status flags
   always_ff @(posedge clk) begin
      if (rst || (por_s[1] && !rst))
         status_q <= swwc_pkg::STATUS_RST;
      else begin
         if (wr_hit(swwc_pkg::ADDR_STATUS))
            status_q <= {bus.wdata[7:5], status_q[4:3], bus.wdata[2:0]};
         if (do_sleep) begin
            status_q[swwc_pkg::PD_BIT] <= 1'b0;
            status_q[swwc_pkg::TO_BIT] <= 1'b1;
         end
         if (wdt_timeout)
            status_q[swwc_pkg::TO_BIT] <= 1'b0;
         else if (op.watchdog_clear_op_op) begin
            status_q[swwc_pkg::TO_BIT] <= 1'b1;
            status_q[swwc_pkg::PD_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Interrupt control and flags; hardware set wins over clear
   always_ff @(posedge clk) begin
      if (rst || core_reset) begin
         interrupt_control_main_q  <= swwc_pkg::INTERRUPT_CONTROL_MAIN_RST;
         pa_last_q <= swwc_pkg::ZERO8;
         pb_last_q <= swwc_pkg::ZERO8;
      end else begin
         pa_last_q <= pa_s2;
         pb_last_q <= pb_s2;
         if (wr_hit(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN))
            interrupt_control_main_q <= bus.wdata;
         if (edge_hit)
            interrupt_control_main_q[swwc_pkg::INTF_BIT] <= 1'b1;
         if (pin_change)
            interrupt_control_main_q[swwc_pkg::IOCF_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_change_enable_a_q   <= swwc_pkg::ZERO8;
         pin_change_enable_b_q   <= swwc_pkg::ZERO8;
         peripheral_irq_enable_a_q   <= swwc_pkg::ZERO8;
         peripheral_irq_enable_b_q   <= swwc_pkg::ZERO8;
         option_q <= swwc_pkg::OPTION_RST;
      end else begin
         if (wr_hit(swwc_pkg::ADDR_PIN_CHANGE_ENABLE_A))
            pin_change_enable_a_q <= bus.wdata;
         if (wr_hit(swwc_pkg::ADDR_PIN_CHANGE_ENABLE_B))
            pin_change_enable_b_q <= bus.wdata;
         if (wr_hit(swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_A))
            peripheral_irq_enable_a_q <= bus.wdata;
         if (wr_hit(swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_B))
            peripheral_irq_enable_b_q <= bus.wdata & 8'hDF;
         if (wr_hit(swwc_pkg::ADDR_OPTION))
            option_q <= bus.wdata;
      end
   end

   // ==========================================================
   // Read port, one cycle latency
   always_ff @(posedge clk) begin
      if (rst)
         rdata <= swwc_pkg::ZERO8;
      else if (bus.rd) begin
         case (bus.addr)
            swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN:  rdata <= interrupt_control_main_q;
            swwc_pkg::ADDR_PIN_CHANGE_ENABLE_A:    rdata <= pin_change_enable_a_q;
            swwc_pkg::ADDR_PIN_CHANGE_ENABLE_B:    rdata <= pin_change_enable_b_q;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_A:    rdata <= peripheral_irq_enable_a_q;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_ENABLE_B:    rdata <= peripheral_irq_enable_b_q;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_A:    rdata <= periph_flags_a;
            swwc_pkg::ADDR_PERIPHERAL_IRQ_FLAGS_B:    rdata <= periph_flags_b & 8'hDF;
            swwc_pkg::ADDR_STATUS:  rdata <= status_q;
            swwc_pkg::ADDR_OPTION:  rdata <= option_q;
            swwc_pkg::ADDR_FUSE_LO: rdata <= fuse_q[7:0];
            swwc_pkg::ADDR_FUSE_HI: rdata <= {2'b11, fuse_q[13:8]};
            swwc_pkg::ADDR_SLPSTAT: rdata <= {6'h00, state_q};
            default:                rdata <= swwc_pkg::ZERO8;
         endcase
      end else
         rdata <= swwc_pkg::ZERO8;
   end

   // ==========================================================
   // Core side outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_clk_en    <= 1'b1;
         core_reset    <= 1'b1;
         prefetch_next <= 1'b0;
         vector_irq    <= 1'b0;
         asleep        <= 1'b0;
      end else begin
         core_reset    <= reset_req;
         // Clock stays gated from sleep entry until wake
         cpu_clk_en    <= !(do_sleep ||
                           (state_q == swwc_pkg::SWWC_SLEEP && !wake_irq));
         prefetch_next <= op.sleep_op;
         // Next instruction runs first, then vector if enabled
         vector_irq    <= state_q == swwc_pkg::SWWC_WAKE &&
                          irq_pending && interrupt_control_main_q[swwc_pkg::GIE_BIT];
         asleep        <= do_sleep ||
                          (state_q == swwc_pkg::SWWC_SLEEP && !wake_irq);
      end
   end

   // Pins and analog enables hold while asleep
   always_ff @(posedge clk) begin
      if (rst) begin
         io_out             <= swwc_pkg::ZERO8;
         io_oe              <= swwc_pkg::ZERO8;
         analog_en          <= swwc_pkg::ZERO8;
         analog_supply_rail <= 1'b1;
      end else begin
         // Sleep leaves the analog enables as they were at entry
         if (state_q != swwc_pkg::SWWC_SLEEP && !do_sleep) begin
            io_out    <= io_out_core;
            io_oe     <= io_oe_core;
            analog_en <= analog_en_core;
         end
         analog_supply_rail <= !(do_sleep ||
                           (state_q == swwc_pkg::SWWC_SLEEP && !wake_irq));
      end
   end
endmodule : swwc_core

/* File: testbench/swwc_core_props.sv */
// Checker for the sleep and watchdog control block
`timescale 1ns/1ps
module swwc_core_props (
   input wire logic               clk,
   input wire logic               rst,
   input wire swwc_pkg::swwc_op_s op,
   input wire logic               reset_pin_n,
   input wire logic               por_event,
   input wire logic [7:0]         io_out,
   input wire logic [7:0]         io_oe,
   input wire logic [7:0]         analog_en,
   input wire logic               cpu_clk_en,
   input wire logic               core_reset,
   input wire logic               prefetch_next,
   input wire logic               analog_supply_rail,
   input wire logic               asleep
);
   // ==========================================================
   // Sequences
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_enter;
      op.sleep_op ##1 asleep;
   endsequence
   sequence s_por;
      asleep && por_event;
   endsequence
   sequence s_pin;
      asleep && !reset_pin_n;
   endsequence
   // ==========================================================
   // Properties
   AST_PREFETCH: assert property (op.sleep_op |=> prefetch_next)
      else $error("no prefetch after power-down");
   AST_ENTER_OFF: assert property (s_enter
      |-> !cpu_clk_en && !analog_supply_rail)
      else $error("clock or rail still on at sleep entry");
   AST_CLK_OFF: assert property (asleep |-> !cpu_clk_en)
      else $error("cpu clock runs in sleep");
   AST_RAIL_OFF: assert property (asleep |-> !analog_supply_rail)
      else $error("analog rail on in sleep");
   AST_IO_HOLD: assert property (asleep && $past(asleep)
      |-> $stable(io_out) && $stable(io_oe))
      else $error("pin drive changed in sleep");
   AST_AN_HOLD: assert property (asleep && $past(asleep)
      |-> $stable(analog_en))
      else $error("analog enables changed in sleep");
   AST_POR_WAKE: assert property (s_por |-> ##[1:6] core_reset)
      else $error("power-on event did not wake");
   AST_PIN_WAKE: assert property (s_pin |-> ##[1:6] core_reset)
      else $error("reset pin did not wake");
   AST_ENTER_SRC: assert property ($rose(asleep) |-> $past(op.sleep_op))
      else $error("sleep entered without power-down");
endmodule : swwc_core_props

bind swwc_core swwc_core_props u_props (
   .clk                (clk),
   .rst                (rst),
   .op                 (op),
   .reset_pin_n        (reset_pin_n),
   .por_event          (por_event),
   .io_out             (io_out),
   .io_oe              (io_oe),
   .analog_en          (analog_en),
   .cpu_clk_en         (cpu_clk_en),
   .core_reset         (core_reset),
   .prefetch_next      (prefetch_next),
   .analog_supply_rail (analog_supply_rail),
   .asleep             (asleep)
);

/* File: testbench/swwc_tb.sv */
// Self-checking bench for the sleep and watchdog control block
`timescale 1ns/1ps
module testbench;
   // ==========================================================
   // Signals
   localparam int TICKS = 20;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   swwc_pkg::swwc_bus_s bus = '0;
   swwc_pkg::swwc_op_s  op = '0;
   logic [13:0]         fuse_word = 14'h3FFF;
   logic                pin_n = 1'b1;
   logic                por = 1'b0;
   logic                edge_pin = 1'b0;
   logic [7:0]          pins_a = 8'h00;
   logic [7:0]          io_core = 8'h00;
   logic [7:0]          oe_core = 8'h00;
   logic [7:0]          an_core = 8'h00;
   logic [7:0]          rdata, analog_en, io_out, io_oe;
   logic                clk_en, core_reset, prefetch, vec, rail, asleep;
   int                  n_fail = 0, checked = 0, cycles = 0;
   int                  n_vec = 0, n_rst = 0, c, r, g;

   swwc_core #(.WDT_TICKS(TICKS)) u_dut (
      .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .op(op),
      .fuse_word(fuse_word), .reset_pin_n(pin_n), .por_event(por),
      .bor_event(1'b0), .edge_pin(edge_pin), .pins_a_in(pins_a),
      .pins_b_in(8'h00), .periph_flags_a(8'h00), .periph_flags_b(8'h00),
      .io_out_core(io_core), .io_oe_core(oe_core),
      .analog_en_core(an_core), .cpu_clk_en(clk_en),
      .core_reset(core_reset), .prefetch_next(prefetch),
      .vector_irq(vec), .analog_supply_rail(rail),
      .analog_en(analog_en), .io_out(io_out), .io_oe(io_oe),
      .asleep(asleep));

   always #25 clk = ~clk;
   // Hang guard: every scenario is short, so 20000 cycles suffice
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (vec === 1'b1) n_vec <= n_vec + 1;
      if (core_reset === 1'b1) n_rst <= n_rst + 1;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic ok(input logic cond);
      chk({7'h00, cond}, 8'h01);
   endtask : ok
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin bus.wr <= 1'b1; bus.addr <= a; bus.wdata <= d; end
      @(posedge clk) bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) begin bus.rd <= 1'b1; bus.addr <= a; end
      @(posedge clk) bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   task automatic pulse(input logic slp);
      @(posedge clk) begin op.sleep_op <= slp; op.watchdog_clear_op_op <= !slp; end
      @(posedge clk) op <= '0;
   endtask : pulse
   // Waits for a reset pulse (w=0) or for the wake (w=1), bounded
   task automatic wait_on(input int w, output int n);
      n = 0;
      do begin
         @(posedge clk) #1 n++;
      end while (!(w == 0 ? core_reset === 1'b1 : asleep === 1'b0) && n < 300);
   endtask : wait_on
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd(swwc_pkg::ADDR_STATUS, swwc_pkg::STATUS_RST);
      rd(swwc_pkg::ADDR_OPTION, swwc_pkg::OPTION_RST);
      rd(swwc_pkg::ADDR_FUSE_LO, 8'hFF);
      rd(swwc_pkg::ADDR_FUSE_HI, 8'hFF);
      wr(4'hF, 8'h5A);
      rd(4'hF, 8'h00);
      $display("test regs done");
   endtask : t_regs
   task automatic t_edge_wake();
      for (g = 0; g < 2; g++) begin
         wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, g ? 8'h90 : 8'h10);
         @(posedge clk) begin
            io_core <= 8'h3C;
            oe_core <= 8'hF0;
            an_core <= 8'h81;
         end
         pulse(1'b1);
         @(posedge clk) begin
            io_core <= 8'hC3;
            oe_core <= 8'h0F;
            an_core <= 8'h18;
         end
         #1 ok(asleep === 1'b1 && clk_en === 1'b0);
         ok(rail === 1'b0);
         rd(swwc_pkg::ADDR_STATUS, 8'h10);
         chk(io_out, 8'h3C);
         chk(io_oe, 8'hF0);
         chk(analog_en, 8'h81);
         r = n_vec;
         @(posedge clk) edge_pin <= 1'b1;
         wait_on(1, c);
         ok(asleep === 1'b0 && c < 20);
         repeat (3) @(posedge clk);
         ok(n_vec - r == g);
         @(posedge clk) edge_pin <= 1'b0;
         wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, 8'h00);
      end
      $display("test edge wake done");
   endtask : t_edge_wake
   task automatic t_noop();
      wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, 8'h10);
      @(posedge clk) edge_pin <= 1'b1;
      repeat (5) @(posedge clk);
      pulse(1'b0);
      pulse(1'b1);
      @(posedge clk) #1 ok(asleep === 1'b0);
      rd(swwc_pkg::ADDR_STATUS, 8'h18);
      @(posedge clk) edge_pin <= 1'b0;
      wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, 8'h00);
      $display("test no-op sleep done");
   endtask : t_noop
   task automatic t_ioc_wake();
      wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, 8'h08);
      wr(swwc_pkg::ADDR_PIN_CHANGE_ENABLE_A, 8'h01);
      rd(swwc_pkg::ADDR_PIN_CHANGE_ENABLE_A, 8'h01);
      pulse(1'b1);
      @(posedge clk) pins_a <= 8'h01;
      wait_on(1, c);
      ok(c < 20);
      wr(swwc_pkg::ADDR_INTERRUPT_CONTROL_MAIN, 8'h00);
      wr(swwc_pkg::ADDR_PIN_CHANGE_ENABLE_A, 8'h00);
      $display("test pin-change wake done");
   endtask : t_ioc_wake
   task automatic t_wdt();
      for (g = 0; g < 2; g++) begin
         wr(swwc_pkg::ADDR_OPTION, g ? 8'h09 : 8'h00);
         pulse(1'b0);
         wait_on(0, c);
         ok(c >= (TICKS << g) - 3 && c <= (TICKS << g) + 3);
      end
      rd(swwc_pkg::ADDR_STATUS, 8'h08);
      wr(swwc_pkg::ADDR_OPTION, 8'h00);
      r = n_rst;
      repeat (6) begin
         pulse(1'b0);
         repeat (12) @(posedge clk);
      end
      ok(n_rst == r);
      pulse(1'b1);
      wait_on(1, c);
      ok(n_rst == r && c >= TICKS && c <= TICKS + 2);
      wait_on(0, c);
      // Without the clear on wake the reset would come two cycles sooner
      ok(c >= TICKS + 1 && c <= TICKS + 3);
      wr(swwc_pkg::ADDR_OPTION, 8'hFF);
      $display("test watchdog done");
   endtask : t_wdt
   task automatic t_reset_wake();
      for (g = 0; g < 2; g++) begin
         pulse(1'b0);
         pulse(1'b1);
         @(posedge clk) begin por <= g; pin_n <= g; end
         wait_on(0, c);
         ok(c < 8);
         @(posedge clk) begin por <= 1'b0; pin_n <= 1'b1; end
         repeat (6) @(posedge clk);
      end
      $display("test reset wake done");
   endtask : t_reset_wake
   task automatic t_fuse_off();
      @(posedge clk) begin fuse_word <= 14'h3FF7; rst <= 1'b1; end
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(swwc_pkg::ADDR_FUSE_LO, 8'hF7);
      wr(swwc_pkg::ADDR_OPTION, 8'h00);
      r = n_rst;
      repeat (100) @(posedge clk);
      ok(n_rst == r);
      $display("test fuse off done");
   endtask : t_fuse_off
   task automatic end_of_test();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_regs();
      t_edge_wake();
      t_noop();
      t_ioc_wake();
      t_wdt();
      t_reset_wake();
      t_fuse_off();
      end_of_test();
   end
endmodule : testbench
